/* logic/csl_code_security_lock.v */
// Design decisions made here: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/1ps
`default_nettype none
`include "csl_defs.vh"
module csl_code_security_lock (
   // clock and reset
   input  wire        clk,
   input  wire        sys_rst,
   // avalon-mm slave
   input  wire [3:0]  avs_address,
   input  wire        avs_read,
   input  wire        avs_write,
   input  wire [31:0] avs_writedata,
   output reg  [31:0] avs_readdata,
   output wire        avs_waitrequest,
   // programmer port
   input  wire        program_strobe,
   input  wire [15:0] prg_addr,
   input  wire [7:0]  prg_data,
   input  wire        verify_req,
   output reg  [7:0]  verify_data,
   output reg         verify_valid,
   output reg         program_strobe_reject,
   // program memory side
   output wire [13:0] code_addr,
   input  wire [7:0]  code_rdata,
   output reg         code_we,
   output reg  [7:0]  code_wdata,
   // core side
   input  wire        code_table_read,
   input  wire        fetch_external,
   output wire        table_read_block,
   input  wire        external_access_pin,
   output reg         ea_latched
);

   // ----------------------------------------
   // lock state and key storage
   // ----------------------------------------
   // lock bits, active low: a one leaves that protection off
   reg  [1:0]  lock_bits_byte_r;
   reg  [1:0]  lock_bits_byte_nxt;
   // set once any key byte other than the erased value is stored
   reg         key_set_r;
   reg         key_set_nxt;
   // key array, one byte per low address pattern
   reg  [7:0]  key_mem [0:`CSL_KEY_DEPTH-1];
   // write strobe for the key array
   reg         key_we_nxt;
   // loop index for the key array reset
   integer     i;

   // ----------------------------------------
   // pin synchronisers and latch control
   // ----------------------------------------
   // strobe synchroniser plus one stage for edge detection
   reg  [2:0]  strb_s;
   // external access pin synchroniser
   reg  [1:0]  ea_s;
   // low during reset and in the first cycle after it
   reg         rst_seen_r;
   reg         ea_latched_nxt;

   // ----------------------------------------
   // programmer and verify path
   // ----------------------------------------
   // programming outputs, next values
   reg         code_we_nxt;
   reg  [7:0]  code_wdata_nxt;
   reg         program_strobe_reject_nxt;
   // verify request, one cycle behind the pin
   reg         vreq_q;
   reg         verify_valid_nxt;
   reg  [7:0]  verify_data_nxt;

   // ----------------------------------------
   // register bus
   // ----------------------------------------
   // high in the cycle in which the answer stands
   reg         ack_r;
   reg         ack_nxt;
   reg  [31:0] avs_readdata_nxt;
   // key byte pointer for the register window
   reg  [5:0]  key_idx_r;
   reg  [5:0]  key_idx_nxt;

   // ----------------------------------------
   // decoded conditions
   // ----------------------------------------
   wire        lock1;
   wire        lock2;
   wire        strobe_rise;
   wire        in_code;
   wire        in_key;
   wire        in_lock;
   wire        bus_req;
   wire [5:0]  key_sel;

   // a zero in lock bit one switches on the basic protection
   assign lock1 = ~lock_bits_byte_r[`CSL_LOCK1_BIT];
   // bit two only counts while bit one is on
   assign lock2 = lock1 & ~lock_bits_byte_r[`CSL_LOCK2_BIT];   // R8

   // image regions seen on the programmer address
   assign in_code = (prg_addr <= `CSL_CODE_LAST);
   assign in_key  = (prg_addr >= `CSL_KEY_BASE) && (prg_addr <= `CSL_KEY_LAST);   // R9
   assign in_lock = (prg_addr == `CSL_LOCK_ADDR);   // R10

   // key byte chosen by the low six address bits
   assign key_sel = prg_addr[5:0];   // R12

   // code memory shares the low address bits
   assign code_addr = prg_addr[13:0];

   // with lock bit one on, external table reads are kept away from internal code
   assign table_read_block = lock1 & code_table_read & fetch_external;   // R3

   // one wait state: waitrequest drops in the second cycle of a request
   assign bus_req         = avs_read | avs_write;
   assign avs_waitrequest = bus_req & ~ack_r;

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   // strobe synchroniser, cleared so a strobe held high through reset gives an edge right after reset
   always @(posedge clk) begin
      if (sys_rst) begin
         strb_s <= 3'h0;
      end else begin
         strb_s <= {strb_s[1:0], program_strobe};
      end
   end

   // rising edge of the synchronised strobe
   assign strobe_rise = strb_s[1] & ~strb_s[2];

   // pin synchroniser runs through reset so the latch sees the live pin
   always @(posedge clk) begin
      ea_s <= {ea_s[0], external_access_pin};
   end

   // ----------------------------------------
   // external access latch
   // ----------------------------------------
   // pin taken in the first cycle after reset, then held while locked
   always @* begin
      ea_latched_nxt = ea_latched;
      if (!rst_seen_r || !lock1) begin
         ea_latched_nxt = ea_s[1];   // R4
      end
   end

   // latch flops
   always @(posedge clk) begin
      if (sys_rst) begin
         rst_seen_r <= 1'b0;
         ea_latched <= 1'b0;
      end else begin
         rst_seen_r <= 1'b1;
         ea_latched <= ea_latched_nxt;
      end
   end

   // ----------------------------------------
   // programming path
   // ----------------------------------------
   // decode one programming strobe into a write, a key store or a refusal
   always @* begin
      code_we_nxt        = 1'b0;
      code_wdata_nxt     = code_wdata;
      program_strobe_reject_nxt    = 1'b0;
      key_we_nxt         = 1'b0;
      key_set_nxt        = key_set_r;
      lock_bits_byte_nxt = lock_bits_byte_r;
      if (strobe_rise) begin
         if (lock1 && !in_lock) begin
            // lock bit one refuses all further programming except writes to the lock byte
            program_strobe_reject_nxt = 1'b1;   // R5
         end else if (in_code) begin
            code_we_nxt    = 1'b1;
            code_wdata_nxt = prg_data;
         end else if (in_key) begin
            key_we_nxt = 1'b1;   // R9
            if (prg_data != `CSL_ERASED) begin
               key_set_nxt = 1'b1;   // R2
            end
         end else if (in_lock) begin
            // zero bits program, a one leaves the bit as it is
            lock_bits_byte_nxt[`CSL_LOCK1_BIT] = lock_bits_byte_r[`CSL_LOCK1_BIT]
                                                 & prg_data[`CSL_LOCK1_BIT];   // R10
            // bit two only with bit one already on or set by this write
            if (!prg_data[`CSL_LOCK1_BIT] || lock1) begin
               lock_bits_byte_nxt[`CSL_LOCK2_BIT] = lock_bits_byte_r[`CSL_LOCK2_BIT]
                                                    & prg_data[`CSL_LOCK2_BIT];   // R8
            end
         end
      end
   end

   // programming flops; lock bits come up unprogrammed
   always @(posedge clk) begin
      if (sys_rst) begin
         code_we          <= 1'b0;
         code_wdata       <= 8'h00;
         program_strobe_reject      <= 1'b0;
         key_set_r        <= 1'b0;
         lock_bits_byte_r <= `CSL_CTRL_RST;
      end else begin
         code_we          <= code_we_nxt;
         code_wdata       <= code_wdata_nxt;
         program_strobe_reject      <= program_strobe_reject_nxt;
         key_set_r        <= key_set_nxt;
         lock_bits_byte_r <= lock_bits_byte_nxt;
      end
   end

   // ----------------------------------------
   // key array
   // ----------------------------------------
   // erased to all ones, one byte stored per accepted strobe to the key region
   always @(posedge clk) begin
      if (sys_rst) begin
         for (i = 0; i < `CSL_KEY_DEPTH; i = i + 1) begin
            key_mem[i] <= `CSL_ERASED;   // R7
         end
      end else if (key_we_nxt) begin
         key_mem[key_sel] <= prg_data;   // R9
      end
   end

   // ----------------------------------------
   // verify readout
   // ----------------------------------------
   // an all-ones key byte inverts to zero and leaves the code plain
   always @* begin
      verify_valid_nxt = vreq_q & ~lock2;   // R6
      verify_data_nxt  = verify_data;
      if (vreq_q) begin
         if (lock2) begin
            verify_data_nxt = 8'h00;   // R6
         end else if (in_key) begin
            verify_data_nxt = key_mem[key_sel];
         end else if (in_lock) begin
            verify_data_nxt = {6'h3f, lock_bits_byte_r};
         end else begin
            verify_data_nxt = code_rdata ^ ~key_mem[key_sel];   // R1 R2 R12
         end
      end
   end

   // verify flops
   always @(posedge clk) begin
      if (sys_rst) begin
         vreq_q       <= 1'b0;
         verify_valid <= 1'b0;
         verify_data  <= 8'h00;
      end else begin
         vreq_q       <= verify_req;
         verify_valid <= verify_valid_nxt;
         verify_data  <= verify_data_nxt;
      end
   end

   // ----------------------------------------
   // register bus slave
   // ----------------------------------------
   // read data loads in the wait cycle so it stands when waitrequest drops
   always @* begin
      ack_nxt          = bus_req & ~ack_r;
      key_idx_nxt      = key_idx_r;
      avs_readdata_nxt = avs_readdata;
      if (bus_req && !ack_r) begin
         case (avs_address)
            `CSL_REG_CTRL:   avs_readdata_nxt = {30'h0, lock_bits_byte_r};
            `CSL_REG_STAT:   avs_readdata_nxt = {27'h0, ea_latched, key_set_r,
                                                 lock2, lock1, table_read_block};
            `CSL_REG_KEYIDX: avs_readdata_nxt = {26'h0, key_idx_r};
            `CSL_REG_KEYDAT: avs_readdata_nxt = {24'h0, key_mem[key_idx_r]};
            default:         avs_readdata_nxt = 32'h0;
         endcase
      end
      // a write lands only at the edge where waitrequest is low
      if (avs_write && ack_r && avs_address == `CSL_REG_KEYIDX) begin
         key_idx_nxt = avs_writedata[5:0];
      end
   end

   // bus flops
   always @(posedge clk) begin
      if (sys_rst) begin
         ack_r        <= 1'b0;
         avs_readdata <= 32'h0;
         key_idx_r    <= 6'h00;
      end else begin
         ack_r        <= ack_nxt;
         avs_readdata <= avs_readdata_nxt;
         key_idx_r    <= key_idx_nxt;
      end
   end

endmodule
`default_nettype wire

/* logic/csl_defs.vh */
// Behaviour
// (R1) with no lock bit programmed, verify reads program memory back
// (R2) a programmed key array makes verify return encrypted bytes
// (R3) lock bit one blocks external table reads from reaching internal code
// (R4) lock bit one latches the external access pin at reset, held till next; the code follows the pin until lock bit one is programmed, then holds it
// (R5) lock bit one rejects every further programming attempt; the code still accepts writes to the lock byte at 4040h
// (R6) both lock bits also disable verify readout entirely
// (R7) key array holds 64 bytes, erased state reads all ones
// (R8) lock bit two acts and may be set only when lock bit one is set
// (R9) image key at 4000h..403fh, key byte ffh means no encryption
// (R10) image lock bits at 4040h bits 0 and 1, zero enables protection
// (R11) programmer uses only none, bit one only, or both combinations
// (R12) encrypted verify combines byte with key byte at low six address bits
`ifndef CSL_DEFS_VH
`define CSL_DEFS_VH
// ----------------------------------------
// image map
// ----------------------------------------
`define CSL_CODE_LAST   16'h3fff
`define CSL_KEY_BASE    16'h4000
`define CSL_KEY_LAST    16'h403f
`define CSL_LOCK_ADDR   16'h4040
`define CSL_LOCK1_BIT   0
`define CSL_LOCK2_BIT   1
`define CSL_KEY_DEPTH   64
`define CSL_ERASED      8'hff
// ----------------------------------------
// avalon registers (byte addresses)
// ----------------------------------------
`define CSL_REG_CTRL    4'h0
`define CSL_REG_STAT    4'h4
`define CSL_REG_KEYIDX  4'h8
`define CSL_REG_KEYDAT  4'hc
`define CSL_CTRL_RST    2'b11
`endif

/* tb/csl_code_security_lock_tb.sv */
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, s) begin cmp_count++; if ((s) !== (e)) begin fails++; \
$display("ERROR %s exp %h got %h", n, e, s); end end
module csl_code_security_lock_tb;
   logic clk = 0, sys_rst = 1, avs_read = 0, avs_write = 0, program_strobe = 0;
   logic verify_req = 0, code_table_read = 0, fetch_external = 0, external_access_pin = 1;
   logic avs_waitrequest, code_we, verify_valid, program_strobe_reject, table_read_block, ea_latched;
   logic [31:0] avs_writedata = 0, avs_readdata;
   logic [15:0] prg_addr = 0; logic [13:0] code_addr; logic [3:0] avs_address = 0;
   logic [7:0] prg_data = 0, verify_data, code_rdata, code_wdata;
   int fails = 0, cmp_count = 0, cyc = 0, rej = 0;
   csl_code_security_lock csl_code_security_lock_inst (.*);
   csl_mem csl_mem_inst (.*);
   initial forever #2.5 clk = ~clk;
   always @(posedge clk) if (++cyc > 2000) close_out(1);
   task automatic pg(logic [15:0] a, logic [7:0] d);
      @(posedge clk) {prg_addr, prg_data, program_strobe} <= {a, d, 1'b1};
      repeat (6) @(posedge clk) rej += program_strobe_reject;
      program_strobe <= 0; repeat (6) @(posedge clk);
   endtask
   task automatic vf(logic [15:0] a, logic v, logic [7:0] e);
      logic s = 0; logic [7:0] d = 0;
      @(posedge clk) {prg_addr, verify_req} <= {a, 1'b1};
      @(posedge clk) verify_req <= 0;
      repeat (4) @(posedge clk) if (verify_valid) {s, d} = {1'b1, verify_data};
      `CHK("valid", v, s) `CHK("data", e, d)
   endtask
   task automatic ac(logic w, logic [3:0] a, logic [31:0] d);
      @(posedge clk) {avs_address, avs_writedata, avs_write, avs_read} <= {a, d, w, !w};
      do @(posedge clk); while (avs_waitrequest);
      if (!w) `CHK("reg", d, avs_readdata)
      {avs_read, avs_write} <= 2'b00;
   endtask
   task automatic t_open;
      ac(0, 4'h4, 32'h10);
      pg(16'h0012, 8'h5a); vf(16'h0012, 1, 8'h5a);
      ac(1, 4'h8, 32'h3f); ac(0, 4'hc, 32'hff);
      ac(0, 4'h2, 32'h0); pg(16'h4012, 8'h0f); pg(16'h4040, 8'hfd);
      vf(16'h0012, 1, 8'haa);
      ac(0, 4'h0, 32'h3); $display("open done");
   endtask
   task automatic t_lock;
      pg(16'h4040, 8'hfe); {code_table_read, fetch_external} <= 2'b11;
      @(posedge clk) `CHK("block", 1'b1, table_read_block)
      external_access_pin <= 0; repeat (4) @(posedge clk);
      ac(0, 4'h4, 32'h1b);
      pg(16'h0012, 8'h00); `CHK("reject", 1, rej)
      vf(16'h0012, 1, 8'haa);
      pg(16'h4040, 8'hfc); vf(16'h0012, 0, 8'h00);
      $display("lock done");
   endtask
   task automatic close_out(int t);
      fails += t; $display("checks %0d fails %0d", cmp_count, fails);
      if (fails == 0 && cmp_count > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask
   initial begin
      repeat (4) @(posedge clk); sys_rst <= 0;
      t_open(); t_lock(); close_out(0);
   end
endmodule
`default_nettype wire

/* tb/csl_mem.sv */
`timescale 1ns/1ps
`default_nettype none
module csl_mem (input wire logic clk, code_we, input wire logic [13:0] code_addr,
   input wire logic [7:0] code_wdata, output logic [7:0] code_rdata);
   logic [7:0] mem_r [0:16383] = '{default: 8'hff};
   assign code_rdata = mem_r[code_addr];
   always @(posedge clk) if (code_we) mem_r[code_addr] <= code_wdata;
endmodule
`default_nettype wire

/* tb/csl_monitor.sv */
`timescale 1ns/1ps
`default_nettype none
module csl_monitor (input wire logic clk, sys_rst, avs_read, avs_waitrequest, verify_req,
   verify_valid, code_we, program_strobe_reject, program_strobe, table_read_block, code_table_read,
   fetch_external);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_ws; $rose(avs_read) |-> avs_waitrequest; endproperty
   a_ws: assert property (p_ws) else $error("read without wait state");
   property p_ak; avs_read && avs_waitrequest |=> !avs_waitrequest; endproperty
   a_ak: assert property (p_ak) else $error("read answer late");
   property p_vl; verify_valid |-> $past(verify_req, 2) || $past(verify_req, 3); endproperty
   a_vl: assert property (p_vl) else $error("verify data without request");
   property p_vp; verify_valid |=> !verify_valid; endproperty
   a_vp: assert property (p_vp) else $error("verify valid too long");
   property p_on; !(code_we && program_strobe_reject); endproperty
   a_on: assert property (p_on) else $error("write and refusal together");
   property p_we; code_we |-> $past(program_strobe, 2); endproperty
   a_we: assert property (p_we) else $error("write without strobe");
   property p_rj; program_strobe_reject |=> !program_strobe_reject; endproperty
   a_rj: assert property (p_rj) else $error("refusal too long");
   property p_tb; table_read_block |-> code_table_read && fetch_external; endproperty
   a_tb: assert property (p_tb) else $error("block without external table read");
   c_v: cover property (verify_valid);
   c_r: cover property (program_strobe_reject);
   c_t: cover property (table_read_block);
endmodule
bind csl_code_security_lock csl_monitor csl_monitor_inst (.*);
`default_nettype wire
